// file: hic_config_regs.sv
// Host interface configuration registers with link-clock access port
`timescale 1ns/1ps
`default_nettype none

module hic_config_regs #(
  parameter int STUCK_CYCLES = hic_pkg::STUCK_CYCLES,
  parameter logic [7:0] ALT_VOLT_RESET = hic_pkg::RST_ALT_VOLT
) (
  input wire logic clk, // Core clock
  input wire logic sys_rst, // Core reset, sync active high
  input wire logic linkClk, // Serial engine clock
  input wire logic linkRst, // Serial engine reset, sync active high
  input wire logic accReq, // Access request pulse (link)
  input wire logic accWrite, // 1 write, 0 read (link)
  input wire logic [7:0] accOffset, // Byte offset within page (link)
  input wire logic accSecondAddr, // Slave address bit 1 was set (link)
  input wire logic [7:0] accWrData, // Write data (link)
  output logic accBusy, // Access in flight (link)
  output logic accDone, // Access finished pulse (link)
  output logic [7:0] accRdData, // Read data, valid with accDone
  input wire logic serialClockLine, // Serial clock pin, asynchronous
  input wire logic irqEvent, // Interrupt pending, active high
  input wire logic firstPgRaw, // First converter power good
  input wire logic secondPgRaw, // Second converter power good
  input wire logic firstTransition, // First converter voltage_transition
  input wire logic secondTransition, // Second converter voltage_transition
  input wire logic ioLockoutRaw, // IO rail undervoltage comparator
  output logic [10:0] secondAltMv, // Alternate voltage in mV
  output logic secondAltAuto, // 1 automatic, 0 forced PWM
  output logic writeRepeatMode, // 1 repeated write, 0 page write
  output logic [3:0] slaveAddrBase, // Effective upper address nibble
  output logic directionFlagPolarity, // 4-wire read flag level
  output logic clockPhase, // 4-wire sampling phase
  output logic clockIdleHigh, // 4-wire clock idle level
  output logic chipSelectHigh, // 4-wire select active high
  output logic fourWireMode, // Port runs 4-wire
  output logic pinTakeover, // General pins serve the interface
  output logic highSpeedAlways, // Permanent high-speed mode
  output logic fastPlusTiming, // Fast-mode-plus timings
  output logic twoWireReset, // Stuck-clock reset pulse
  output logic firstPgOut, // First converter power good
  output logic secondPgOut, // Second converter power good
  output logic ioLockoutOut, // IO rail lockout event
  output logic ioComparatorOn, // IO rail comparator enable
  output logic irqOut, // Interrupt pin value
  output logic irqOe_n // Interrupt pin enable, low drives
);

  typedef struct packed {
    logic busy;
    logic reqTgl;
    logic write;
    logic [7:0] offset;
    logic second;
    logic [7:0] wrData;
    logic ack1;
    logic ack2;
    logic ackSeen;
    logic done;
    logic [7:0] rdData;
  } hic_link_type;

  typedef struct packed {
    logic req1;
    logic req2;
    logic reqSeen;
    logic ackTgl;
    logic [7:0] rdData;
    logic [7:0] altVolt;
    logic [7:0] pageCtl;
    logic [7:0] portSetup;
    logic [7:0] portSetup2;
    logic [7:0] appSetupA;
    logic [7:0] supervision;
    logic sclk1;
    logic sclk2;
    logic [19:0] stuckCnt;
    logic busReset;
    logic [10:0] altMv;
    logic firstPg;
    logic secondPg;
    logic lockout;
    logic irqPin;
    logic irqOen;
  } hic_core_type;

  localparam logic [19:0] STUCK_LIMIT = 20'(STUCK_CYCLES);

  localparam hic_link_type LINK_RST = '0;
  localparam hic_core_type CORE_RST = '{
    req1: 1'b0, req2: 1'b0, reqSeen: 1'b0, ackTgl: 1'b0, rdData: 8'h00_00,
    altVolt: ALT_VOLT_RESET & hic_pkg::MASK_ALT_VOLT,
    pageCtl: hic_pkg::RST_PAGE_CTL,
    portSetup: hic_pkg::RST_PORT_SETUP,
    portSetup2: hic_pkg::RST_PORT_SETUP2,
    appSetupA: hic_pkg::RST_APP_SETUP_A,
    supervision: hic_pkg::RST_SUPERVISION,
    sclk1: 1'b1, sclk2: 1'b1, stuckCnt: 20'h0_0000, busReset: 1'b0,
    altMv: 11'(hic_pkg::VOLT_BASE_MV), firstPg: 1'b0, secondPg: 1'b0,
    lockout: 1'b0, irqPin: 1'b1, irqOen: 1'b0};

  hic_link_type lk_ff, nxt_lk;
  hic_core_type c_ff, nxt_c;

  // Link side: hold request fields stable until the core answers
  always_comb begin
    nxt_lk = lk_ff;
    // Toggle crosses on two flops; only the second one is ever compared
    nxt_lk.ack1 = c_ff.ackTgl;
    nxt_lk.ack2 = lk_ff.ack1;
    nxt_lk.done = 1'b0;
    if (lk_ff.ack2 != lk_ff.ackSeen) begin
      nxt_lk.ackSeen = lk_ff.ack2;
      nxt_lk.rdData = c_ff.rdData;
      nxt_lk.done = 1'b1;
      nxt_lk.busy = 1'b0;
    end else if (accReq && !lk_ff.busy) begin
      // Requests while busy are dropped; the serial engine waits on accBusy
      nxt_lk.busy = 1'b1;
      nxt_lk.write = accWrite;
      nxt_lk.offset = accOffset;
      nxt_lk.second = accSecondAddr;
      nxt_lk.wrData = accWrData;
      nxt_lk.reqTgl = ~lk_ff.reqTgl;
    end
  end

  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      lk_ff <= LINK_RST;
    end else begin
      lk_ff <= nxt_lk;
    end
  end

  logic [9:0] regAddr;
  logic addrValid;
  logic spiMode;
  logic [2:0] pageHi;
  logic [7:0] readVal;
  logic pageCtlHit;

  // Page decode for the held request
  always_comb begin
    spiMode = ~c_ff.portSetup2[hic_pkg::IF_TYPE_BIT];
    pageHi = 3'b000;
    regAddr = 10'h0_00;
    addrValid = 1'b0;
    if (!spiMode) begin
      pageHi = {1'b0, c_ff.pageCtl[2:1]} + (lk_ff.second ? 3'b010 : 3'b000);
      regAddr = {pageHi[1:0], lk_ff.offset};
      addrValid = ~pageHi[2];
    end else begin
      regAddr = {c_ff.pageCtl[2:0], lk_ff.offset[6:0]};
      addrValid = (c_ff.pageCtl[2:0] == 3'b000) || (c_ff.pageCtl[2:0] == 3'b001) ||
                  (c_ff.pageCtl[2:0] == 3'b010) || (c_ff.pageCtl[2:0] == 3'b100);
    end
    // Page control answers at every window start of a valid page, else upper pages stay unreachable
    pageCtlHit = (regAddr[6:0] == hic_pkg::OFF_PAGE_CTL[6:0]);
    readVal = 8'h00_00;
    if (!addrValid) begin
      readVal = 8'h00_00;
    end else if (regAddr == hic_pkg::OFF_ALT_VOLT) begin
      readVal = c_ff.altVolt;
    end else if (pageCtlHit) begin
      readVal = c_ff.pageCtl;
    end else if (regAddr == hic_pkg::OFF_PORT_SETUP) begin
      readVal = c_ff.portSetup;
    end else if (regAddr == hic_pkg::OFF_PORT_SETUP2) begin
      readVal = c_ff.portSetup2;
    end else if (regAddr == hic_pkg::OFF_APP_SETUP_A) begin
      readVal = c_ff.appSetupA;
    end else if (regAddr == hic_pkg::OFF_SUPERVISION) begin
      readVal = c_ff.supervision;
    end
  end

  logic irqActiveLevel;

  always_comb begin
    nxt_c = c_ff;
    irqActiveLevel = 1'b0;
    nxt_c.req1 = lk_ff.reqTgl;
    nxt_c.req2 = c_ff.req1;
    nxt_c.sclk1 = serialClockLine;
    nxt_c.sclk2 = c_ff.sclk1;
    nxt_c.busReset = 1'b0;
    // Request fields are stable since the toggle left the link side
    if (c_ff.req2 != c_ff.reqSeen) begin
      nxt_c.reqSeen = c_ff.req2;
      nxt_c.ackTgl = ~c_ff.ackTgl;
      nxt_c.rdData = lk_ff.write ? 8'h00_00 : readVal;
      if (lk_ff.write && addrValid) begin
        if (regAddr == hic_pkg::OFF_ALT_VOLT) begin
          nxt_c.altVolt = lk_ff.wrData & hic_pkg::MASK_ALT_VOLT;
        end else if (pageCtlHit) begin
          nxt_c.pageCtl = lk_ff.wrData & hic_pkg::MASK_PAGE_CTL;
        end else if (regAddr == hic_pkg::OFF_PORT_SETUP) begin
          nxt_c.portSetup = lk_ff.wrData & hic_pkg::MASK_PORT_SETUP;
        end else if (regAddr == hic_pkg::OFF_PORT_SETUP2) begin
          nxt_c.portSetup2 = lk_ff.wrData & hic_pkg::MASK_PORT_SETUP2;
        end else if (regAddr == hic_pkg::OFF_APP_SETUP_A) begin
          nxt_c.appSetupA = lk_ff.wrData & hic_pkg::MASK_APP_SETUP_A;
        end else if (regAddr == hic_pkg::OFF_SUPERVISION) begin
          nxt_c.supervision = lk_ff.wrData & hic_pkg::MASK_SUPERVISION;
        end
      end
      // Return bit taken after the write, so writing it set also returns
      if (nxt_c.pageCtl[hic_pkg::PAGE_RETURN_BIT]) begin
        nxt_c.pageCtl[2:0] = 3'b000;
      end
    end
    // Only meaningful while the port runs 2-wire
    if (!spiMode && c_ff.appSetupA[hic_pkg::STUCK_EN_BIT] && !c_ff.sclk2) begin
      // Saturates so a line held low gives one pulse only
      if (c_ff.stuckCnt != STUCK_LIMIT) begin
        nxt_c.stuckCnt = c_ff.stuckCnt + 20'h0_0001;
      end
      if (c_ff.stuckCnt == STUCK_LIMIT - 20'h0_0001) begin
        nxt_c.busReset = 1'b1;
      end
    end else begin
      nxt_c.stuckCnt = 20'h0_0000;
    end
    nxt_c.altMv = 11'(hic_pkg::VOLT_BASE_MV) +
                  11'(c_ff.altVolt[6:0]) * 11'(hic_pkg::VOLT_STEP_MV);
    nxt_c.firstPg = (c_ff.supervision[hic_pkg::FIRST_PG_HOLD_BIT] && firstTransition) ?
                    c_ff.firstPg : firstPgRaw;
    nxt_c.secondPg = (c_ff.supervision[hic_pkg::SECOND_PG_HOLD_BIT] && secondTransition) ?
                     c_ff.secondPg : secondPgRaw;
    nxt_c.lockout = ioLockoutRaw & ~c_ff.supervision[hic_pkg::IO_LOCKOUT_OFF_BIT];
    irqActiveLevel = c_ff.appSetupA[hic_pkg::IRQ_LEVEL_BIT];
    nxt_c.irqPin = irqActiveLevel ? irqEvent : ~irqEvent;
    // Open drain only pulls low; the high level comes from the pull-up
    nxt_c.irqOen = c_ff.appSetupA[hic_pkg::IRQ_TYPE_BIT] & nxt_c.irqPin;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      c_ff <= CORE_RST;
    end else begin
      c_ff <= nxt_c;
    end
  end

  assign accBusy = lk_ff.busy;
  assign accDone = lk_ff.done;
  assign accRdData = lk_ff.rdData;
  assign secondAltMv = c_ff.altMv;
  assign secondAltAuto = c_ff.altVolt[hic_pkg::ALT_MODE_BIT];
  assign writeRepeatMode = c_ff.pageCtl[hic_pkg::WRITE_SEQ_BIT];
  assign slaveAddrBase = (c_ff.portSetup[7:4] == 4'h0_0) ?
                         hic_pkg::HW_DEFAULT_BASE : c_ff.portSetup[7:4];
  assign directionFlagPolarity = c_ff.portSetup[hic_pkg::DIR_POL_BIT];
  assign clockPhase = c_ff.portSetup[hic_pkg::CLK_PHASE_BIT];
  assign clockIdleHigh = c_ff.portSetup[hic_pkg::CLK_IDLE_BIT];
  assign chipSelectHigh = c_ff.portSetup[hic_pkg::CS_POL_BIT];
  assign fourWireMode = ~c_ff.portSetup2[hic_pkg::IF_TYPE_BIT];
  assign pinTakeover = ~c_ff.portSetup2[hic_pkg::IF_TYPE_BIT];
  assign highSpeedAlways = c_ff.portSetup2[hic_pkg::HS_ALWAYS_BIT];
  assign fastPlusTiming = c_ff.portSetup2[hic_pkg::FAST_PLUS_BIT];
  assign twoWireReset = c_ff.busReset;
  assign firstPgOut = c_ff.firstPg;
  assign secondPgOut = c_ff.secondPg;
  assign ioLockoutOut = c_ff.lockout;
  assign ioComparatorOn = ~c_ff.supervision[hic_pkg::IO_LOCKOUT_OFF_BIT];
  assign irqOut = c_ff.irqPin;
  assign irqOe_n = c_ff.irqOen;

  logic accessNow;
  assign accessNow = (c_ff.req2 != c_ff.reqSeen);

  a_page_return: assert property (@(posedge clk) disable iff (sys_rst)
    accessNow |=> !c_ff.pageCtl[hic_pkg::PAGE_RETURN_BIT] || c_ff.pageCtl[2:0] == 3'b000)
    else $error("page select not returned after access");

  a_volt_map: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 secondAltMv == 11'(hic_pkg::VOLT_BASE_MV) +
        11'($past(c_ff.altVolt[6:0])) * 11'(hic_pkg::VOLT_STEP_MV))
    else $error("alternate voltage mapping wrong");

  a_stuck_reset: assert property (@(posedge clk) disable iff (sys_rst)
    twoWireReset |-> c_ff.stuckCnt == STUCK_LIMIT && !fourWireMode)
    else $error("stuck clock reset at wrong count");

  a_stuck_once: assert property (@(posedge clk) disable iff (sys_rst)
    twoWireReset |=> !twoWireReset)
    else $error("stuck clock reset longer than one cycle");

  a_pg_hold: assert property (@(posedge clk) disable iff (sys_rst)
    c_ff.supervision[hic_pkg::FIRST_PG_HOLD_BIT] && firstTransition &&
    $stable(c_ff.supervision) |=> $stable(firstPgOut))
    else $error("power good changed during masked transition");

  a_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 irqOut == ($past(irqEvent) ~^ $past(c_ff.appSetupA[hic_pkg::IRQ_LEVEL_BIT])))
    else $error("interrupt level wrong");

  a_irq_drive: assert property (@(posedge clk) disable iff (sys_rst)
    !c_ff.appSetupA[hic_pkg::IRQ_TYPE_BIT] && $stable(c_ff.appSetupA) |=> !irqOe_n)
    else $error("push-pull interrupt not driven");

  a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (c_ff.pageCtl & ~hic_pkg::MASK_PAGE_CTL) == 8'h00_00 &&
    (c_ff.appSetupA & ~hic_pkg::MASK_APP_SETUP_A) == 8'h00_00)
    else $error("reserved bits set");

  a_lockout_off: assert property (@(posedge clk) disable iff (sys_rst)
    c_ff.supervision[hic_pkg::IO_LOCKOUT_OFF_BIT] |=> !ioLockoutOut)
    else $error("lockout fired while disabled");

  a_done_pulse: assert property (@(posedge linkClk) disable iff (linkRst)
    accDone |=> !accDone && !accBusy)
    else $error("done pulse malformed");

  a_pg_follow: assert property (@(posedge clk) disable iff (sys_rst)
    !c_ff.supervision[hic_pkg::FIRST_PG_HOLD_BIT] |=> firstPgOut == $past(firstPgRaw))
    else $error("power good not following while unmasked");

  a_pg_hold_b: assert property (@(posedge clk) disable iff (sys_rst)
    c_ff.supervision[hic_pkg::SECOND_PG_HOLD_BIT] && secondTransition &&
    $stable(c_ff.supervision) |=> $stable(secondPgOut))
    else $error("second power good changed during masked transition");

  a_lockout_on: assert property (@(posedge clk) disable iff (sys_rst)
    !c_ff.supervision[hic_pkg::IO_LOCKOUT_OFF_BIT] |=> ioLockoutOut == $past(ioLockoutRaw))
    else $error("lockout not following comparator");

  a_stuck_clear: assert property (@(posedge clk) disable iff (sys_rst)
    fourWireMode |=> c_ff.stuckCnt == 20'h0_0000)
    else $error("stuck counter running in four-wire mode");

  a_irq_open: assert property (@(posedge clk) disable iff (sys_rst)
    irqOe_n |-> irqOut)
    else $error("interrupt pin released while value low");

  a_link_hold: assert property (@(posedge linkClk) disable iff (linkRst)
    accBusy && !accDone |=> $stable(lk_ff.write) && $stable(lk_ff.offset) &&
    $stable(lk_ff.second) && $stable(lk_ff.wrData))
    else $error("request fields moved while in flight");

  a_busy_done: assert property (@(posedge linkClk) disable iff (linkRst)
    accDone |-> !accBusy)
    else $error("busy still high with done");

  c_page_return: cover property (@(posedge clk) disable iff (sys_rst)
    accessNow && c_ff.pageCtl[hic_pkg::PAGE_RETURN_BIT] && c_ff.pageCtl[2:0] != 3'b000);
  c_spi_access: cover property (@(posedge clk) disable iff (sys_rst) accessNow && spiMode);
  c_pg_held: cover property (@(posedge clk) disable iff (sys_rst)
    c_ff.supervision[hic_pkg::SECOND_PG_HOLD_BIT] && secondTransition && secondPgRaw != secondPgOut);
  c_link_done: cover property (@(posedge linkClk) disable iff (linkRst) accDone);
  c_stuck_fire: cover property (@(posedge clk) disable iff (sys_rst) twoWireReset);

endmodule : hic_config_regs

`default_nettype wire

// file: hic_config_regs_tb_top.sv
// Self-checking bench for the configuration register slice
`timescale 1ns/1ps
`default_nettype none
module hic_config_regs_tb_top;
  typedef struct packed {logic [7:0] code; logic [10:0] mv; logic aut;} hic_row_type;
  logic clk, sys_rst, linkClk, linkRst, accReq, accWrite, accSecondAddr, accBusy, accDone;
  logic [7:0] accOffset, accWrData, accRdData;
  logic serialClockLine, irqEvent, firstPgRaw, secondPgRaw, firstTransition;
  logic secondTransition, ioLockoutRaw, secondAltAuto, writeRepeatMode, directionFlagPolarity;
  logic clockPhase, clockIdleHigh, chipSelectHigh, fourWireMode, pinTakeover, highSpeedAlways;
  logic fastPlusTiming, twoWireReset, firstPgOut, secondPgOut, ioLockoutOut, ioComparatorOn;
  logic irqOut, irqOe_n;
  logic [10:0] secondAltMv;
  logic [3:0] slaveAddrBase;
  int fails = 0;
  int samples_checked = 0;
  int n, k;
  logic e;
  hic_row_type rows [5] = '{'{8'h00_00, 11'h12C, 1'b0}, '{8'h00_7F, 11'h622, 1'b0},
    '{8'h00_80, 11'h12C, 1'b1}, '{8'h00_FF, 11'h622, 1'b1}, '{8'h00_46, 11'h3E8, 1'b0}};
  hic_config_regs #(.STUCK_CYCLES(20)) hic_config_regs_i (.clk(clk), .sys_rst(sys_rst),
    .linkClk(linkClk), .linkRst(linkRst), .accReq(accReq), .accWrite(accWrite),
    .accOffset(accOffset), .accSecondAddr(accSecondAddr), .accWrData(accWrData),
    .accBusy(accBusy), .accDone(accDone), .accRdData(accRdData),
    .serialClockLine(serialClockLine), .irqEvent(irqEvent), .firstPgRaw(firstPgRaw),
    .secondPgRaw(secondPgRaw), .firstTransition(firstTransition),
    .secondTransition(secondTransition), .ioLockoutRaw(ioLockoutRaw),
    .secondAltMv(secondAltMv), .secondAltAuto(secondAltAuto),
    .writeRepeatMode(writeRepeatMode), .slaveAddrBase(slaveAddrBase),
    .directionFlagPolarity(directionFlagPolarity), .clockPhase(clockPhase),
    .clockIdleHigh(clockIdleHigh), .chipSelectHigh(chipSelectHigh),
    .fourWireMode(fourWireMode), .pinTakeover(pinTakeover), .highSpeedAlways(highSpeedAlways),
    .fastPlusTiming(fastPlusTiming), .twoWireReset(twoWireReset), .firstPgOut(firstPgOut),
    .secondPgOut(secondPgOut), .ioLockoutOut(ioLockoutOut), .ioComparatorOn(ioComparatorOn),
    .irqOut(irqOut), .irqOe_n(irqOe_n));
  hic_host_model hic_host_model_i (.linkClk(linkClk), .accBusy(accBusy), .accDone(accDone),
    .accRdData(accRdData), .accReq(accReq), .accWrite(accWrite), .accOffset(accOffset),
    .accSecondAddr(accSecondAddr), .accWrData(accWrData));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Odd offset keeps the link edges off the core edges; the 48 ns period against 40 ns makes them drift
  initial begin
    linkClk = 1'b0;
    #7;
    forever #24 linkClk = ~linkClk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic cw(input int c);
    repeat (c) @(posedge clk);
    #2;
  endtask : cw
  task automatic acc(input logic wr, input logic [7:0] off, input logic sec,
      input logic [7:0] wd, input int gap, output logic [7:0] rd);
    logic ok;
    hic_host_model_i.access(wr, off, sec, wd, gap, rd, ok);
    chk(11'({ok, accBusy}), 11'h002, "no done");
  endtask : acc
  task automatic wrr(input logic [7:0] off, input logic [7:0] wd);
    logic [7:0] rd;
    acc(1'b1, off, 1'b0, wd, 1, rd);
    cw(3);
  endtask : wrr
  task automatic rdc(input logic [7:0] off, input logic sec, input logic [7:0] exp);
    logic [7:0] rd;
    acc(1'b0, off, sec, 8'h00_00, 5, rd);
    chk(11'(rd), 11'(exp), "read");
  endtask : rdc
  // Holds the serial clock low and counts stuck-reset pulses and when the first came
  task automatic stuckRun;
    n = 0;
    k = 0;
    serialClockLine = 1'b0;
    for (int i = 1; i <= 40; i++) begin
      cw(1);
      if (twoWireReset === 1'b1) begin
        if (n == 0) k = i;
        n++;
      end
    end
    serialClockLine = 1'b1;
    cw(3);
  endtask : stuckRun
  initial begin
    #1_000_000;
    fails++;
    test_done;
  end
  initial begin
    sys_rst = 1'b1;
    linkRst = 1'b1;
    serialClockLine = 1'b1;
    irqEvent = 1'b0;
    firstPgRaw = 1'b0;
    secondPgRaw = 1'b0;
    firstTransition = 1'b0;
    secondTransition = 1'b0;
    ioLockoutRaw = 1'b0;
    cw(10);
    sys_rst = 1'b0;
    linkRst = 1'b0;
    cw(3);
    chk(secondAltMv, 11'h12C, "mv reset");
    chk(11'(slaveAddrBase), 11'h00D, "base reset");
    chk(11'({fourWireMode, irqOut, irqOe_n}), 11'h002, "port reset");
    rdc(8'h00_DA, 1'b0, 8'h00_00);
    foreach (rows[i]) begin
      wrr(8'h00_DA, rows[i].code);
      chk(secondAltMv, rows[i].mv, "mv");
      chk(11'(secondAltAuto), 11'(rows[i].aut), "alt mode");
      rdc(8'h00_DA, 1'b0, rows[i].code);
    end
    wrr(8'h00_00, 8'h00_7A);
    chk(11'(writeRepeatMode), 11'h001, "write seq");
    rdc(8'h00_00, 1'b0, 8'h00_42);
    rdc(8'h00_05, 1'b0, 8'h00_D0);
    rdc(8'h00_05, 1'b1, 8'h00_00);
    wrr(8'h00_05, 8'h00_0F);
    chk(11'({slaveAddrBase, directionFlagPolarity, clockPhase, clockIdleHigh,
      chipSelectHigh}), 11'h0DF, "setup zero base");
    wrr(8'h00_05, 8'h00_A5);
    chk(11'({slaveAddrBase, directionFlagPolarity, clockPhase, clockIdleHigh,
      chipSelectHigh}), 11'h0A5, "setup");
    for (int c = 0; c < 8; c++) begin
      wrr(8'h00_43, 8'(c[2:1]));
      irqEvent = c[0];
      cw(2);
      e = c[1] ? c[0] : ~c[0];
      chk(11'({irqOut, irqOe_n}), 11'({e, c[2] & e}), "irq pin");
    end
    irqEvent = 1'b0;
    stuckRun;
    chk(11'(n), 11'h000, "stuck off");
    wrr(8'h00_43, 8'h00_FF);
    rdc(8'h00_43, 1'b0, 8'h00_13);
    stuckRun;
    chk(11'(n), 11'h001, "stuck pulses");
    chk(11'(k >= 20 && k <= 26), 11'h001, "stuck time");
    wrr(8'h00_44, 8'h00_FF);
    rdc(8'h00_44, 1'b0, 8'h00_E0);
    ioLockoutRaw = 1'b1;
    firstTransition = 1'b1;
    secondTransition = 1'b1;
    firstPgRaw = 1'b1;
    secondPgRaw = 1'b1;
    cw(3);
    chk(11'({firstPgOut, secondPgOut}), 11'h000, "pg held");
    chk(11'({ioLockoutOut, ioComparatorOn}), 11'h000, "io off");
    firstTransition = 1'b0;
    secondTransition = 1'b0;
    cw(3);
    chk(11'({firstPgOut, secondPgOut}), 11'h003, "pg free");
    firstTransition = 1'b1;
    secondTransition = 1'b1;
    firstPgRaw = 1'b0;
    secondPgRaw = 1'b0;
    wrr(8'h00_44, 8'h00_00);
    chk(11'({firstPgOut, secondPgOut}), 11'h000, "pg unmasked");
    chk(11'({ioLockoutOut, ioComparatorOn}), 11'h003, "io on");
    wrr(8'h00_06, 8'h00_FF);
    rdc(8'h00_06, 1'b0, 8'h00_F0);
    chk(11'({fourWireMode, pinTakeover, highSpeedAlways, fastPlusTiming}), 11'h003,
      "two wire");
    wrr(8'h00_06, 8'h00_00);
    chk(11'({fourWireMode, pinTakeover, highSpeedAlways, fastPlusTiming}), 11'h00C,
      "four wire");
    rdc(8'h00_85, 1'b0, 8'h00_A5);
    wrr(8'h00_00, 8'h00_81);
    rdc(8'h00_5A, 1'b0, 8'h00_00);
    sys_rst = 1'b1;
    linkRst = 1'b1;
    cw(3);
    sys_rst = 1'b0;
    linkRst = 1'b0;
    cw(3);
    chk(11'({writeRepeatMode, slaveAddrBase, fourWireMode}), 11'h01A, "mid reset");
    chk(secondAltMv, 11'h12C, "mv mid reset");
    rdc(8'h00_DA, 1'b0, 8'h00_00);
    test_done;
  end
endmodule : hic_config_regs_tb_top
`default_nettype wire

// file: hic_host_model.sv
// Host-side model issuing single-byte accesses on the link port
`timescale 1ns/1ps
`default_nettype none
module hic_host_model (
  input wire logic linkClk, // Link clock
  input wire logic accBusy, // In flight
  input wire logic accDone, // Finished
  input wire logic [7:0] accRdData, // Read data
  output logic accReq, // Request
  output logic accWrite, // Direction
  output logic [7:0] accOffset, // Offset
  output logic accSecondAddr, // Address bit 1
  output logic [7:0] accWrData // Write data
);
  initial begin
    accReq = 1'b0;
    accWrite = 1'b0;
    accOffset = 8'h00_00;
    accSecondAddr = 1'b0;
    accWrData = 8'h00_00;
  end
  // Idle gap models a slow host; released lines go inverted so stale values never pass
  task automatic access(input logic wr, input logic [7:0] off, input logic sec,
      input logic [7:0] wd, input int gap, output logic [7:0] rd, output logic ok);
    ok = 1'b0;
    rd = 8'h00_00;
    repeat (gap) @(posedge linkClk);
    #2;
    accWrite = wr;
    accOffset = off;
    accSecondAddr = sec;
    accWrData = wd;
    accReq = 1'b1;
    @(posedge linkClk);
    #2;
    accReq = 1'b0;
    accWrite = ~wr;
    accOffset = ~off;
    accSecondAddr = ~sec;
    accWrData = ~wd;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge linkClk);
      if (accDone === 1'b1) begin
        ok = 1'b1;
        rd = accRdData;
      end
    end
  endtask : access
endmodule : hic_host_model
`default_nettype wire

// file: hic_pkg.sv
// Shared constants for the host interface configuration register slice
`default_nettype none
package hic_pkg;
  // Register addresses in the 10-bit internal register space
  localparam logic [9:0] OFF_ALT_VOLT = 10'h0_DA;
  localparam logic [9:0] OFF_PAGE_CTL = 10'h1_00;
  localparam logic [9:0] OFF_PORT_SETUP = 10'h1_05;
  localparam logic [9:0] OFF_PORT_SETUP2 = 10'h1_06;
  localparam logic [9:0] OFF_APP_SETUP_A = 10'h1_43;
  localparam logic [9:0] OFF_SUPERVISION = 10'h1_44;

  // Writable bit masks; everything else reads zero
  localparam logic [7:0] MASK_ALT_VOLT = 8'h00_FF;
  localparam logic [7:0] MASK_PAGE_CTL = 8'h00_C7;
  localparam logic [7:0] MASK_PORT_SETUP = 8'h00_FF;
  localparam logic [7:0] MASK_PORT_SETUP2 = 8'h00_F0;
  localparam logic [7:0] MASK_APP_SETUP_A = 8'h00_13;
  localparam logic [7:0] MASK_SUPERVISION = 8'h00_E0;

  // Field positions
  localparam int ALT_MODE_BIT = 7;
  localparam int PAGE_RETURN_BIT = 7;
  localparam int WRITE_SEQ_BIT = 6;
  localparam int DIR_POL_BIT = 3;
  localparam int CLK_PHASE_BIT = 2;
  localparam int CLK_IDLE_BIT = 1;
  localparam int CS_POL_BIT = 0;
  localparam int IF_TYPE_BIT = 7;
  localparam int HS_ALWAYS_BIT = 6;
  localparam int FAST_PLUS_BIT = 5;
  localparam int STUCK_EN_BIT = 4;
  localparam int IRQ_TYPE_BIT = 1;
  localparam int IRQ_LEVEL_BIT = 0;
  localparam int IO_LOCKOUT_OFF_BIT = 7;
  localparam int SECOND_PG_HOLD_BIT = 6;
  localparam int FIRST_PG_HOLD_BIT = 5;

  // Values after reset
  localparam logic [7:0] RST_ALT_VOLT = 8'h00_00;
  localparam logic [7:0] RST_PAGE_CTL = 8'h00_00;
  localparam logic [7:0] RST_PORT_SETUP = 8'h00_D0;
  localparam logic [7:0] RST_PORT_SETUP2 = 8'h00_80;
  localparam logic [7:0] RST_APP_SETUP_A = 8'h00_00;
  localparam logic [7:0] RST_SUPERVISION = 8'h00_00;
  localparam logic [3:0] HW_DEFAULT_BASE = 4'h0_D;

  // Voltage code mapping
  localparam int VOLT_BASE_MV = 300;
  localparam int VOLT_STEP_MV = 10;

  // Stuck serial clock timeout
  localparam int CLK_HZ = 25_000_000;
  localparam int STUCK_TIME_MS = 35;
  localparam int STUCK_CYCLES = (STUCK_TIME_MS * (CLK_HZ / 1000));
endpackage : hic_pkg
`default_nettype wire
